// >>> design/sac_pkg.sv
// Package for the serial ADC control block: control byte layout, modes, timing.
// Assumes a 50 MHz system clock sampling the serial pins.
package sac_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CTRL_W          = 8;
    localparam int unsigned RES_W           = 10;
    localparam int unsigned FRAME_W         = 16;
    localparam int unsigned START_BIT       = 7;
    localparam int unsigned SEL_HI_BIT      = 6;
    localparam int unsigned SEL_LO_BIT      = 4;
    localparam int unsigned POL_BIT         = 3;
    localparam int unsigned TOPO_BIT        = 2;
    localparam int unsigned MODE_HI_BIT     = 1;
    localparam int unsigned MODE_LO_BIT     = 0;
    localparam int unsigned SAR_STEPS       = 12;
    localparam int unsigned RESTART_OK_LEFT = 3;
    localparam int unsigned INT_CONV_NS     = 7500;
    localparam int unsigned INT_CONV_CYC    = (INT_CONV_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [1:0]  MODE_FULL_PD    = 2'h0;
    localparam logic [1:0]  MODE_FAST_PD    = 2'h1;
    localparam logic [1:0]  MODE_INT_CLK    = 2'h2;
    localparam logic [1:0]  MODE_EXT_CLK    = 2'h3;
    localparam logic [15:0] FRAME_RESET     = 16'h0000;
    localparam logic [2:0]  CHAN_RESET      = 3'h0;
    localparam logic [1:0]  MODE_RESET      = 2'h2;
    localparam int unsigned FIFO_DEPTH      = 4;
endpackage

// >>> design/sac_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
module sac_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    // System
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];

    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data_i;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> design/sac_serial_ctrl.sv
// Serial control and readout of an 8-channel 10-bit SAR converter.
// Assumes serial pins arrive asynchronously and are sampled by ref_clk_i.
// The analog core is outside: comparator decisions arrive on sar_bit_i, a
// conversion request leaves on conv_start_o and the finished code returns
// through a small FIFO (sar_valid_i/sar_ready_o).
module sac_serial_ctrl
    import sac_pkg::*;
#(
    parameter int unsigned FIFO_W = RES_W,
    parameter int unsigned FIFO_D = FIFO_DEPTH
) (
    // System
    input  wire logic                   ref_clk_i,
    input  wire logic                   sys_rst_i,
    // Serial pins
    input  wire logic                   cs_n_i,
    input  wire logic                   sclk_i,
    input  wire logic                   sdi_i,
    output logic                        sdo_o,
    output logic                        sdo_oe_o,
    output logic                        conv_strobe_o,
    output logic                        conv_strobe_oe_o,
    // Analog core
    output logic                        conv_start_o,
    output logic [2:0]                  pos_chan_o,
    output logic [2:0]                  neg_chan_o,
    output logic                        neg_is_common_o,
    output logic                        polarity_select_o,
    output logic                        low_power_o,
    output logic                        fast_power_down_o,
    input  wire logic                   sar_bit_i,
    input  wire logic                   sar_valid_i,
    output logic                        sar_ready_o,
    input  wire logic [sac_pkg::RES_W-1:0] sar_data_i
);
    import sac_pkg::*;

    typedef enum {ST_IDLE, ST_CMD, ST_EXT, ST_INT} sac_state_e;

    sac_state_e     state_reg;
    logic [2:0]     cs_sync_reg;
    logic [2:0]     sck_sync_reg;
    logic [1:0]     sdi_sync_reg;
    logic [7:0]     cmd_reg;
    logic [3:0]     bit_cnt_reg;
    logic [4:0]     out_cnt_reg;
    logic [15:0]    frame_reg;
    logic [1:0]     mode_reg;
    logic           ext_strobe_reg;
    logic           int_strobe_reg;
    logic           strobe_pend_reg;
    logic [8:0]     int_cnt_reg;
    logic [RES_W-1:0] result_reg;
    logic           fifo_valid;
    logic [RES_W-1:0] fifo_data;

    // Two flops before use; the third stage only serves edge detection
    wire cs_n     = cs_sync_reg[1];
    wire cs_fall  = cs_sync_reg[2] && !cs_sync_reg[1];
    wire cs_rise  = !cs_sync_reg[2] && cs_sync_reg[1];
    wire sck_rise = !sck_sync_reg[2] && sck_sync_reg[1] && !cs_n;
    wire sck_fall = sck_sync_reg[2] && !sck_sync_reg[1];
    wire sdi      = sdi_sync_reg[1];
    wire [7:0] cmd_next = {cmd_reg[6:0], sdi};
    wire cmd_done = sck_rise && (state_reg == ST_CMD) && (bit_cnt_reg == 4'h7);
    wire [1:0] new_mode = cmd_next[MODE_HI_BIT:MODE_LO_BIT];
    wire restart_ok = (out_cnt_reg <= 5'(RESTART_OK_LEFT));
    wire start_seen = sck_rise && sdi && (state_reg != ST_CMD)
                      && ((state_reg == ST_IDLE) || restart_ok);
    wire ext_mode = (mode_reg == MODE_EXT_CLK);
    // Serial mode drains its copy too, so a stale code never reaches an internal readback
    wire fifo_take = (state_reg == ST_EXT) || (state_reg == ST_INT && int_cnt_reg == 9'h000);

    // Single-ended channel number is bit5,bit4,bit6 from high to low
    function automatic logic [2:0] sgl_chan(input logic [2:0] s);
        return {s[1], s[0], s[2]};
    endfunction

    wire [2:0] sel = cmd_reg[SEL_HI_BIT:SEL_LO_BIT];
    wire [2:0] pair_even = {sel[1:0], 1'b0};
    wire [2:0] pos_sel = cmd_reg[TOPO_BIT] ? sgl_chan(sel) : (pair_even | {2'b00, sel[2]});
    wire [2:0] neg_sel = pair_even | {2'b00, !sel[2]};

    // Result sourced through the FIFO keeps the analog core decoupled
    sac_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (sar_valid_i),
        .in_ready_o  (sar_ready_o),
        .in_data_i   (sar_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take),
        .out_data_o  (fifo_data)
    );

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cs_sync_reg  <= 3'h7;
            sck_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
        end
        else
        begin
            cs_sync_reg  <= {cs_sync_reg[1:0], cs_n_i};
            sck_sync_reg <= {sck_sync_reg[1:0], sclk_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
        end
    end

    // Control byte capture and conversion sequencing
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg       <= ST_IDLE;
            cmd_reg         <= 8'h00;
            bit_cnt_reg     <= 4'h0;
            mode_reg        <= MODE_RESET;
            conv_start_o    <= 1'b0;
            strobe_pend_reg <= 1'b0;
            int_cnt_reg     <= 9'h000;
        end
        else
        begin
            conv_start_o <= 1'b0;
            if (cs_rise && state_reg != ST_INT)
            begin
                state_reg <= ST_IDLE;
            end
            else if (start_seen)
            begin
                state_reg   <= ST_CMD;
                cmd_reg     <= 8'h01;
                bit_cnt_reg <= 4'h1;
            end
            else if (sck_rise && state_reg == ST_CMD)
            begin
                cmd_reg     <= cmd_next;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (cmd_done)
                    strobe_pend_reg <= 1'b1;
            end
            // Conversion begins at the falling edge after the eighth bit
            if (strobe_pend_reg && sck_fall)
            begin
                strobe_pend_reg <= 1'b0;
                conv_start_o    <= 1'b1;
                // Power-down codes keep the previous clock mode for this one
                if (cmd_reg[MODE_HI_BIT])
                    mode_reg <= cmd_reg[MODE_HI_BIT:MODE_LO_BIT];
                if ((cmd_reg[MODE_HI_BIT] ? cmd_reg[MODE_LO_BIT] : (mode_reg == MODE_EXT_CLK)))
                    state_reg <= ST_EXT;
                else
                begin
                    state_reg   <= ST_INT;
                    int_cnt_reg <= 9'(INT_CONV_CYC);
                end
            end
            else if (state_reg == ST_INT && int_cnt_reg != 9'h000)
                int_cnt_reg <= int_cnt_reg - 9'h001;
            else if (state_reg == ST_INT && fifo_valid)
                state_reg <= ST_IDLE;
            if (cs_rise)
                strobe_pend_reg <= 1'b0;
        end
    end

    // Analog core configuration follows the latched control byte
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pos_chan_o        <= CHAN_RESET;
            neg_chan_o        <= CHAN_RESET;
            neg_is_common_o   <= 1'b1;
            polarity_select_o <= 1'b1;
            low_power_o       <= 1'b0;
            fast_power_down_o <= 1'b0;
        end
        else
        begin
            if (strobe_pend_reg && sck_fall)
            begin
                pos_chan_o        <= pos_sel;
                neg_chan_o        <= neg_sel;
                neg_is_common_o   <= cmd_reg[TOPO_BIT];
                polarity_select_o <= cmd_reg[POL_BIT];
                fast_power_down_o <= (cmd_reg[MODE_HI_BIT:MODE_LO_BIT] == MODE_FAST_PD);
                low_power_o       <= 1'b0;
            end
            else if (state_reg == ST_IDLE && !cmd_reg[MODE_HI_BIT] && cmd_reg[START_BIT])
                low_power_o <= 1'b1;
        end
    end

    // Output framing: leading zero, ten bits, zeros in the two sub-bit slots, trailing zeros
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            frame_reg      <= FRAME_RESET;
            out_cnt_reg    <= 5'h00;
            result_reg     <= '0;
            sdo_o          <= 1'b0;
            ext_strobe_reg <= 1'b0;
            int_strobe_reg <= 1'b1;
        end
        else
        begin
            if (strobe_pend_reg && sck_fall && (cmd_reg[MODE_HI_BIT] ? cmd_reg[MODE_LO_BIT] : ext_mode))
            begin
                ext_strobe_reg <= 1'b1;
                out_cnt_reg    <= 5'(SAR_STEPS);
                sdo_o          <= 1'b0;
            end
            else if (state_reg == ST_EXT && sck_fall && out_cnt_reg != 5'h00)
            begin
                ext_strobe_reg <= 1'b0;
                sdo_o          <= (out_cnt_reg > 5'h2) ? sar_bit_i : 1'b0;
                out_cnt_reg    <= out_cnt_reg - 5'h01;
            end
            else if (sck_fall)
            begin
                ext_strobe_reg <= 1'b0;
                sdo_o          <= frame_reg[FRAME_W-1];
                frame_reg      <= {frame_reg[FRAME_W-2:0], 1'b0};
            end
            if (strobe_pend_reg && sck_fall && !(cmd_reg[MODE_HI_BIT] ? cmd_reg[MODE_LO_BIT] : ext_mode))
                int_strobe_reg <= 1'b0;
            else if (state_reg == ST_INT && int_cnt_reg == 9'h000 && fifo_valid)
            begin
                int_strobe_reg <= 1'b1;
                result_reg     <= fifo_data;
                frame_reg      <= {fifo_data, 6'h00};
                out_cnt_reg    <= 5'h00;
            end
            if (state_reg == ST_EXT && sar_valid_i)
                result_reg <= sar_data_i;
        end
    end

    // Strobe floats with chip select high only in serial-clocked mode
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sdo_oe_o         <= 1'b0;
            conv_strobe_oe_o <= 1'b1;
            conv_strobe_o    <= 1'b1;
        end
        else
        begin
            sdo_oe_o         <= !cs_n;
            conv_strobe_oe_o <= ext_mode ? !cs_n : 1'b1;
            conv_strobe_o    <= ext_mode ? (ext_strobe_reg && !cs_fall) : int_strobe_reg;
        end
    end
endmodule

// >>> tb/sac_checker.sv
// Concurrent checks on the pins of the serial ADC control block.
// Assumes the host keeps chip select high for long stretches between frames.
module sac_checker
    import sac_pkg::*;
(
    // System
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    // Serial pins
    input wire logic       cs_n_i,
    input wire logic       sclk_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire logic       conv_strobe_o,
    input wire logic       conv_strobe_oe_o,
    // Core side
    input wire logic       conv_start_o,
    input wire logic [2:0] pos_chan_o,
    input wire logic [2:0] neg_chan_o,
    input wire logic       neg_is_common_o,
    input wire logic       polarity_select_o,
    input wire logic       low_power_o
);
    // Slack over the conversion count covers the pin synchronisers
    localparam logic [9:0] LOW_MAX = 10'(INT_CONV_CYC + 25);
    logic [9:0] low_cnt_reg;
    logic [9:0] low_cnt_next;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    assign low_cnt_next = (conv_strobe_oe_o && !conv_strobe_o && !sclk_i) ? low_cnt_reg + 10'h001 : 10'h000;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            low_cnt_reg <= 10'h000;
        else
            low_cnt_reg <= low_cnt_next;
    end
    AST_SDO_OFF: assert property (cs_n_i [*5] |-> !sdo_oe_o)
        else $error("serial output driven with chip select high");
    AST_STB_FLOAT: assert property ($fell(conv_strobe_oe_o) |-> cs_n_i)
        else $error("strobe released while chip select low");
    AST_SDO_EDGE: assert property ($changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o) |->
        !$past(sclk_i, 3) || !$past(sclk_i, 4) || !$past(sclk_i, 5))
        else $error("serial output moved away from a falling edge");
    AST_STB_PULSE: assert property ($rose(conv_strobe_o) && ($past(sclk_i, 5) || $past(sclk_i, 6)) |->
        conv_strobe_o [*8] ##1 !conv_strobe_o)
        else $error("strobe pulse not one serial period");
    AST_INT_BOUND: assert property (low_cnt_reg <= LOW_MAX)
        else $error("strobe low too long");
    AST_START_FALL: assert property (conv_start_o |->
        ($past(sclk_i, 5) || $past(sclk_i, 6)) && !$past(sclk_i, 1) ##1 !conv_start_o)
        else $error("conversion start not tied to a falling edge");
    AST_CFG_WHEN: assert property (!$stable({pos_chan_o, neg_is_common_o, polarity_select_o}) |-> !$past(cs_n_i, 3))
        else $error("configuration changed with chip select high");
    AST_DIFF_PAIR: assert property (!neg_is_common_o && $changed(pos_chan_o) |->
        neg_chan_o == {pos_chan_o[2:1], ~pos_chan_o[0]})
        else $error("differential pair mismatch");
    CVR_START: cover property (conv_start_o);
    CVR_PWR: cover property ($rose(low_power_o));
    CVR_INT_DONE: cover property ($rose(conv_strobe_o) && !sclk_i);
endmodule

bind sac_serial_ctrl sac_checker sac_checker_i (.ref_clk_i, .sys_rst_i, .cs_n_i, .sclk_i, .sdo_o, .sdo_oe_o,
    .conv_strobe_o, .conv_strobe_oe_o, .conv_start_o, .pos_chan_o, .neg_chan_o, .neg_is_common_o,
    .polarity_select_o, .low_power_o);

// >>> tb/sac_host_model.sv
// Serial host model: mode-0 clock master sending control bytes and reading frames.
// Assumes frame() is called from one process only.
module sac_host_model
(
    // System
    input  wire logic   ref_clk_i,
    // Serial pins
    output logic        cs_n_o,
    output logic        sclk_o,
    output logic        sdi_o,
    input  wire logic   sdo_i,
    input  wire logic   conv_strobe_i,
    // Comparator decisions
    output logic        sar_bit_o,
    // Results
    output logic        rx_stb_o,
    output logic [15:0] rx_word_o,
    output logic        timed_out_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b1;
        sar_bit_o = 1'b0;
        rx_stb_o = 1'b0;
        rx_word_o = 16'h0000;
        timed_out_o = 1'b0;
    end
    // Data set while clock low, sampled late in the high phase to cover pin sync delay
    task automatic bit_cyc(input logic d, output logic q);
        sdi_o <= d;
        repeat (4) @(posedge ref_clk_i);
        sclk_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        q = sdo_i;
        sclk_o <= 1'b0;
    endtask
    task automatic frame(input int pre, input logic [7:0] ctrl, input logic [11:0] dec, input bit intl);
        logic q;
        int   n;
        cs_n_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        for (n = 0; n < pre; n++)
            bit_cyc(1'b0, q);
        for (n = 7; n >= 0; n--)
            bit_cyc(ctrl[n], q);
        if (intl)
        begin
            sdi_o <= 1'b0;
            repeat (12) @(posedge ref_clk_i);
            for (n = 0; n < 1000 && !conv_strobe_i; n++)
                @(posedge ref_clk_i);
            if (!conv_strobe_i)
                timed_out_o <= 1'b1;
        end
        for (n = 15; n >= 0; n--)
        begin
            // The decision set here is taken at the falling edge that ended the previous bit, once it clears the pin sync
            sar_bit_o <= (n > 2 && n < 15) ? dec[n - 3] : ~sar_bit_o;
            bit_cyc(1'b0, q);
            rx_word_o[n] <= q;
        end
        repeat (4) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        sdi_o <= 1'b1;
        // Let chip select pass the pin sync so power-down state has settled
        repeat (8) @(posedge ref_clk_i);
        rx_stb_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_stb_o <= 1'b0;
        repeat (32) @(posedge ref_clk_i);
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench: host model on the serial pins, a stub analog core behind.
// Assumes the checker binds itself to the design.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sac_pkg::*;
    typedef struct packed {logic [15:0] frame; logic [9:0] cfg;} sac_exp_s;
    logic        ref_clk_i, sys_rst_i, cs_n_i, sclk_i, sdi_i, sar_bit_i, sar_valid_i, sdo_o, sdo_oe_o;
    logic        conv_strobe_o, conv_strobe_oe_o, conv_start_o, neg_is_common_o, polarity_select_o;
    logic        low_power_o, fast_power_down_o, sar_ready_o, rx_stb, timed_out;
    logic [2:0]  pos_chan_o, neg_chan_o;
    logic [9:0]  sar_data_i;
    logic [15:0] rx_word;
    int          seed = 6;
    int          n_fail = 0;
    int          tests_run = 0;
    sac_exp_s    exp_q[$];
    sac_exp_s    mon_e;
    sac_serial_ctrl sac_serial_ctrl_i (.ref_clk_i, .sys_rst_i, .cs_n_i, .sclk_i, .sdi_i, .sdo_o, .sdo_oe_o,
        .conv_strobe_o, .conv_strobe_oe_o, .conv_start_o, .pos_chan_o, .neg_chan_o, .neg_is_common_o,
        .polarity_select_o, .low_power_o, .fast_power_down_o, .sar_bit_i, .sar_valid_i, .sar_ready_o, .sar_data_i);
    sac_host_model sac_host_model_i (.ref_clk_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i), .sdo_i(sdo_o),
        .conv_strobe_i(conv_strobe_o), .sar_bit_o(sar_bit_i), .rx_stb_o(rx_stb), .rx_word_o(rx_word),
        .timed_out_o(timed_out));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Core stub offers the result at once and holds it until taken
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            sar_valid_i <= 1'b0;
        else if (conv_start_o)
            sar_valid_i <= 1'b1;
        else if (sar_ready_o)
            sar_valid_i <= 1'b0;
    end
    task automatic chk_frame(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: frame got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_cfg(input logic [9:0] e, input logic [9:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: config got %b expected %b", $time, g, e);
        end
    endtask
    always @(posedge ref_clk_i)
    begin
        if (rx_stb)
        begin
            mon_e = exp_q.pop_front();
            chk_frame(mon_e.frame, rx_word);
            chk_cfg(mon_e.cfg, {pos_chan_o, neg_is_common_o ? 3'h0 : neg_chan_o, neg_is_common_o,
                polarity_select_o, low_power_o, fast_power_down_o});
        end
    end
    task automatic run(input logic [7:0] ctrl, input bit intl);
        logic [11:0] dec;
        logic [2:0]  s;
        sac_exp_s    e;
        dec = 12'($random(seed));
        s = ctrl[6:4];
        sar_data_i <= dec[11:2];
        e.frame = {1'h0, dec[11:2], 5'h00};
        e.cfg = {s[1:0], s[2], ctrl[2] ? 3'h0 : {s[1:0], ~s[2]}, ctrl[2], ctrl[3], !ctrl[1], ctrl[1:0] == 2'h1};
        exp_q.push_back(e);
        sac_host_model_i.frame($random(seed) & 3, ctrl, dec, intl);
    endtask
    task automatic summarize();
        $display("Checks run: %0d, mismatches: %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        sys_rst_i = 1'b1;
        sar_data_i = 10'h000;
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        for (int i = 0; i < 16; i++)
            run({1'h1, i[2:0], 1'($random(seed)), i[3], 2'h3}, 1'b0);
        for (int m = 0; m < 2; m++)
            run({1'h1, 3'($random(seed)), 2'h3, 2'(m)}, 1'b0);
        run(8'hFF, 1'b0);
        for (int k = 0; k < 3; k++)
            run({1'h1, 3'($random(seed)), 2'($random(seed)), 2'h2}, 1'b1);
        repeat (50) @(posedge ref_clk_i);
        summarize();
    end
    // Hang guard: a host timeout or a stuck run ends in the same report
    initial
    begin
        for (int w = 0; w < 90000 && !timed_out; w++)
            @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end
endmodule
